// File: core/jtap_debug_port.sv
`timescale 1ns/100ps
// Contract
// - Controller is a sixteen-state machine
// - Transitions use mode-select at test-clock rise
// - Power-on reset enters Test-Logic-Reset
// - All shift registers move LSB first
// - Four-bit instruction, top bit on exit edge
// - Shift-IR outputs captured value 0x01
// - Instruction latched in Update-IR state
// - Latched instruction selects data path
// - Exit, Pause, Exit2 states do nothing
// - Last data bit shifts on exit edge
// - Shift-DR outputs values captured in Capture-DR
// - Parallel outputs update only in Update-DR
// - Five high mode-select periods force reset
// - CPU runs scanned instructions, result readable
// - Flow, step, program and combined breaks
// - Four break points in three arrangements
// - Data output undriven unless shifting
module jtap_debug_port #(
  parameter logic [31:0] IDCODE_VALUE = 32'h0000_0001 // Arbitrary value
) (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        tck,
  input  wire logic        tms,
  input  wire logic        tdi,
  output wire logic        tdo,
  output wire logic        tdoOe,
  output wire logic [15:0] cpuInstr,
  output wire logic        cpuInstrStb,
  input  wire logic [7:0]  cpuResult,
  input  wire logic        cpuResultValid,
  output wire logic        ocdDirty,
  input  wire logic [15:0] pc,
  input  wire logic        pcValid,
  input  wire logic        flowChange,
  input  wire logic [15:0] dataAddr,
  input  wire logic        dataAccess,
  output wire logic        breakReq
);

  // ==========================================================
  // State
  typedef struct packed {
    logic                   tckMeta;
    logic                   tckSync;
    logic                   tckPrev;
    logic                   tmsMeta;
    logic                   tmsSync;
    logic                   tdiMeta;
    logic                   tdiSync;
    jtap_pkg::jtap_state_t  tap;
    logic [3:0]             irShift;
    logic [3:0]             irHold;
    logic [71:0]            drShift;
    logic                   tdo;
    logic                   tdoOe;
    logic [15:0]            cpuInstr;
    logic                   cpuStb;
    logic [7:0]             ocdData;
    logic                   ocdDirty;
    jtap_pkg::jtap_bp_cfg_t bpCfg;
  } jtap_core_st_t;

  localparam jtap_core_st_t ST_RST = '{
    tap:     jtap_pkg::TAP_RESET,
    irHold:  jtap_pkg::INS_IDCODE,
    bpCfg:   '0,
    default: '0
  };

  jtap_core_st_t s;
  jtap_core_st_t n;

  jtap_bp_if bpLink ();

  // ==========================================================
  // Functions
  function automatic jtap_pkg::jtap_state_t tapNext(
    input jtap_pkg::jtap_state_t cur,
    input logic                  m
  );
    case (cur)
      jtap_pkg::TAP_RESET:  tapNext = m ? jtap_pkg::TAP_RESET : jtap_pkg::TAP_IDLE;
      jtap_pkg::TAP_IDLE:   tapNext = m ? jtap_pkg::DR_SELECT : jtap_pkg::TAP_IDLE;
      jtap_pkg::DR_SELECT:  tapNext = m ? jtap_pkg::IR_SELECT : jtap_pkg::DR_CAPTURE;
      jtap_pkg::DR_CAPTURE: tapNext = m ? jtap_pkg::DR_EXIT1  : jtap_pkg::DR_SHIFT;
      jtap_pkg::DR_SHIFT:   tapNext = m ? jtap_pkg::DR_EXIT1  : jtap_pkg::DR_SHIFT;
      jtap_pkg::DR_EXIT1:   tapNext = m ? jtap_pkg::DR_UPDATE : jtap_pkg::DR_PAUSE;
      jtap_pkg::DR_PAUSE:   tapNext = m ? jtap_pkg::DR_EXIT2  : jtap_pkg::DR_PAUSE;
      jtap_pkg::DR_EXIT2:   tapNext = m ? jtap_pkg::DR_UPDATE : jtap_pkg::DR_SHIFT;
      jtap_pkg::DR_UPDATE:  tapNext = m ? jtap_pkg::DR_SELECT : jtap_pkg::TAP_IDLE;
      jtap_pkg::IR_SELECT:  tapNext = m ? jtap_pkg::TAP_RESET : jtap_pkg::IR_CAPTURE;
      jtap_pkg::IR_CAPTURE: tapNext = m ? jtap_pkg::IR_EXIT1  : jtap_pkg::IR_SHIFT;
      jtap_pkg::IR_SHIFT:   tapNext = m ? jtap_pkg::IR_EXIT1  : jtap_pkg::IR_SHIFT;
      jtap_pkg::IR_EXIT1:   tapNext = m ? jtap_pkg::IR_UPDATE : jtap_pkg::IR_PAUSE;
      jtap_pkg::IR_PAUSE:   tapNext = m ? jtap_pkg::IR_EXIT2  : jtap_pkg::IR_PAUSE;
      jtap_pkg::IR_EXIT2:   tapNext = m ? jtap_pkg::IR_UPDATE : jtap_pkg::IR_SHIFT;
      jtap_pkg::IR_UPDATE:  tapNext = m ? jtap_pkg::DR_SELECT : jtap_pkg::TAP_IDLE;
      default:              tapNext = jtap_pkg::TAP_RESET;
    endcase
  endfunction : tapNext

  // Serial length of the register the instruction selects
  function automatic logic [6:0] drLen(
    input logic [3:0] ins
  );
    if (ins == jtap_pkg::INS_IDCODE)
    begin
      drLen = jtap_pkg::LEN_IDCODE;
    end
    else if (ins == jtap_pkg::INS_CPU_SCAN)
    begin
      drLen = jtap_pkg::LEN_CPU;
    end
    else if (ins == jtap_pkg::INS_OCD_COMM)
    begin
      drLen = jtap_pkg::LEN_OCD;
    end
    else if (ins == jtap_pkg::INS_BP_SCAN)
    begin
      drLen = jtap_pkg::LEN_BP;
    end
    else
    begin
      drLen = jtap_pkg::LEN_BYPASS;
    end
  endfunction : drLen

  // Shift right one place, new bit enters at the top of the chain
  function automatic logic [71:0] drInsert(
    input logic [71:0] dr,
    input logic        bitIn,
    input logic [6:0]  len
  );
    drInsert = '0;
    for (int i = 0; i < jtap_pkg::DR_W - 1; i++)
    begin
      drInsert[i] = (7'(i + 1) == len) ? bitIn : dr[i + 1];
    end
    drInsert[71] = (len == jtap_pkg::LEN_BP) ? bitIn : 1'b0;
  endfunction : drInsert

  // ==========================================================
  // Next state
  always_comb
  begin
    logic tckRise;
    logic tckFall;
    tckRise = s.tckSync && !s.tckPrev;
    tckFall = !s.tckSync && s.tckPrev;
    n       = s;

    // Pin synchronisers
    n.tckMeta = tck;
    n.tckSync = s.tckMeta;
    n.tckPrev = s.tckSync;
    n.tmsMeta = tms;
    n.tmsSync = s.tmsMeta;
    n.tdiMeta = tdi;
    n.tdiSync = s.tdiMeta;

    n.cpuStb = 1'b0;

    // CPU side of the communication register
    if (cpuResultValid)
    begin
      n.ocdData = cpuResult;
    end

    if (tckRise)
    begin
      n.tap = tapNext(s.tap, s.tmsSync);
      case (s.tap)
        jtap_pkg::TAP_RESET:
        begin
          n.irHold = jtap_pkg::INS_IDCODE;
        end
        jtap_pkg::IR_CAPTURE:
        begin
          n.irShift = jtap_pkg::IR_CAPTURE_VAL;
        end
        jtap_pkg::IR_SHIFT:
        begin
          // Exit edge also shifts, so the top bit lands here
          n.irShift = {s.tdiSync, s.irShift[3:1]};
        end
        jtap_pkg::IR_UPDATE:
        begin
          n.irHold = s.irShift;
        end
        jtap_pkg::DR_CAPTURE:
        begin
          // Parallel inputs of the selected register
          if (s.irHold == jtap_pkg::INS_IDCODE)
          begin
            n.drShift = {40'h00_0000_0000, IDCODE_VALUE};
          end
          else if (s.irHold == jtap_pkg::INS_CPU_SCAN)
          begin
            n.drShift = {56'h00_0000_0000_0000, s.cpuInstr};
          end
          else if (s.irHold == jtap_pkg::INS_OCD_COMM)
          begin
            n.drShift = {63'h0, s.ocdDirty, s.ocdData};
          end
          else if (s.irHold == jtap_pkg::INS_BP_SCAN)
          begin
            n.drShift = s.bpCfg;
          end
          else
          begin
            n.drShift = '0;
          end
        end
        jtap_pkg::DR_SHIFT:
        begin
          n.drShift = drInsert(s.drShift, s.tdiSync, drLen(s.irHold));
        end
        jtap_pkg::DR_UPDATE:
        begin
          if (s.irHold == jtap_pkg::INS_CPU_SCAN)
          begin
            n.cpuInstr = s.drShift[15:0];
            n.cpuStb   = 1'b1;
          end
          else if (s.irHold == jtap_pkg::INS_OCD_COMM)
          begin
            n.ocdDirty = 1'b0;
          end
          else if (s.irHold == jtap_pkg::INS_BP_SCAN)
          begin
            n.bpCfg = jtap_pkg::jtap_bp_cfg_t'(s.drShift);
          end
          else
          begin
            n.cpuStb = 1'b0;
          end
        end
        default:
        begin
          n.cpuStb = 1'b0;
        end
      endcase
    end

    // Output side moves half a test-clock later
    if (tckFall)
    begin
      n.tdoOe = (s.tap == jtap_pkg::IR_SHIFT) || (s.tap == jtap_pkg::DR_SHIFT);
      if (s.tap == jtap_pkg::IR_SHIFT)
      begin
        n.tdo = s.irShift[0];
      end
      else if (s.tap == jtap_pkg::DR_SHIFT)
      begin
        n.tdo = s.drShift[0];
      end
      else
      begin
        n.tdo = 1'b0;
      end
    end

    // A new CPU byte beats a debugger clear
    if (cpuResultValid)
    begin
      n.ocdDirty = 1'b1;
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      s <= ST_RST;
    end
    else
    begin
      s <= n;
    end
  end

  // ==========================================================
  // Break point unit
  assign bpLink.cfg = s.bpCfg;

  jtap_break_unit u_break (
    .mclk       (mclk),
    .rst        (rst),
    .bp         (bpLink),
    .pc         (pc),
    .pcValid    (pcValid),
    .flowChange (flowChange),
    .dataAddr   (dataAddr),
    .dataAccess (dataAccess)
  );

  // ==========================================================
  // Outputs
  assign tdo         = s.tdo;
  assign tdoOe       = s.tdoOe;
  assign cpuInstr    = s.cpuInstr;
  assign cpuInstrStb = s.cpuStb;
  assign ocdDirty    = s.ocdDirty;
  assign breakReq    = bpLink.breakReq;

endmodule : jtap_debug_port

// File: core/jtap_pkg.sv
package jtap_pkg;

  // ==========================================================
  // Controller states
  typedef enum logic [3:0] {
    TAP_RESET  = 4'hF,
    TAP_IDLE   = 4'hC,
    DR_SELECT  = 4'h7,
    DR_CAPTURE = 4'h6,
    DR_SHIFT   = 4'h2,
    DR_EXIT1   = 4'h1,
    DR_PAUSE   = 4'h3,
    DR_EXIT2   = 4'h0,
    DR_UPDATE  = 4'h5,
    IR_SELECT  = 4'h4,
    IR_CAPTURE = 4'hE,
    IR_SHIFT   = 4'hA,
    IR_EXIT1   = 4'h9,
    IR_PAUSE   = 4'hB,
    IR_EXIT2   = 4'h8,
    IR_UPDATE  = 4'hD
  } jtap_state_t;

  // ==========================================================
  // Instructions
  localparam int         IR_W           = 4;
  localparam logic [3:0] IR_CAPTURE_VAL = 4'h1;
  localparam logic [3:0] INS_IDCODE     = 4'h1;
  localparam logic [3:0] INS_CPU_SCAN   = 4'h8;
  localparam logic [3:0] INS_BP_SCAN    = 4'h9;
  localparam logic [3:0] INS_OCD_COMM   = 4'hA;
  localparam logic [3:0] INS_BYPASS     = 4'hF;

  // ==========================================================
  // Data register lengths
  localparam int         DR_W       = 72;
  localparam int         ADDR_W     = 16;
  localparam int         CPU_W      = 16;
  localparam logic [6:0] LEN_BYPASS = 7'h01;
  localparam logic [6:0] LEN_IDCODE = 7'h20;
  localparam logic [6:0] LEN_CPU    = 7'h10;
  localparam logic [6:0] LEN_OCD    = 7'h09;
  localparam logic [6:0] LEN_BP     = 7'h48;

  // ==========================================================
  // Break point configuration
  localparam logic [1:0] BP_MODE_PROG4     = 2'h0;
  localparam logic [1:0] BP_MODE_PROG_DATA = 2'h1;
  localparam logic [1:0] BP_MODE_RANGE     = 2'h2;

  typedef struct packed {
    logic [3:0][15:0] addr;
    logic [3:0]       bpEn;
    logic             stepEn;
    logic             flowEn;
    logic [1:0]       mode;
  } jtap_bp_cfg_t;

endpackage : jtap_pkg

// File: core/jtap_bp_if.sv
`timescale 1ns/100ps
interface jtap_bp_if;
  jtap_pkg::jtap_bp_cfg_t cfg;
  logic                   breakReq;

  modport tap (
    output cfg,
    input  breakReq
  );

  modport unit (
    input  cfg,
    output breakReq
  );
endinterface : jtap_bp_if

// File: core/jtap_break_unit.sv
`timescale 1ns/100ps
module jtap_break_unit (
  input  wire logic        mclk,
  input  wire logic        rst,
  jtap_bp_if.unit          bp,
  input  wire logic [15:0] pc,
  input  wire logic        pcValid,
  input  wire logic        flowChange,
  input  wire logic [15:0] dataAddr,
  input  wire logic        dataAccess
);

  typedef struct packed {
    logic breakReq;
  } jtap_bu_st_t;

  jtap_bu_st_t s;
  jtap_bu_st_t n;

  // Address compare, enabled slot only
  function automatic logic addrHit(
    input logic [15:0] a,
    input logic [15:0] refAddr,
    input logic        en
  );
    addrHit = en && (a == refAddr);
  endfunction : addrHit

  // ==========================================================
  // Break decision
  always_comb
  begin
    logic progHit;
    logic dataHit;
    progHit = 1'b0;
    dataHit = 1'b0;
    n       = s;
    case (bp.cfg.mode)
      jtap_pkg::BP_MODE_PROG_DATA:
      begin
        progHit = addrHit(pc, bp.cfg.addr[0], bp.cfg.bpEn[0])
               || addrHit(pc, bp.cfg.addr[1], bp.cfg.bpEn[1])
               || addrHit(pc, bp.cfg.addr[2], bp.cfg.bpEn[2]);
        dataHit = addrHit(dataAddr, bp.cfg.addr[3], bp.cfg.bpEn[3]);
      end
      jtap_pkg::BP_MODE_RANGE:
      begin
        progHit = addrHit(pc, bp.cfg.addr[0], bp.cfg.bpEn[0])
               || addrHit(pc, bp.cfg.addr[1], bp.cfg.bpEn[1]);
        // Slot 3 is the mask: set bits are ignored
        dataHit = addrHit(dataAddr & ~bp.cfg.addr[3], bp.cfg.addr[2] & ~bp.cfg.addr[3],
                          bp.cfg.bpEn[2]);
      end
      default:
      begin
        progHit = addrHit(pc, bp.cfg.addr[0], bp.cfg.bpEn[0])
               || addrHit(pc, bp.cfg.addr[1], bp.cfg.bpEn[1])
               || addrHit(pc, bp.cfg.addr[2], bp.cfg.bpEn[2])
               || addrHit(pc, bp.cfg.addr[3], bp.cfg.bpEn[3]);
      end
    endcase
    n.breakReq = (pcValid && (progHit || bp.cfg.stepEn))
              || (flowChange && bp.cfg.flowEn)
              || (dataAccess && dataHit);
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      s <= '0;
    end
    else
    begin
      s <= n;
    end
  end

  assign bp.breakReq = s.breakReq;

endmodule : jtap_break_unit

// File: testbench/jtap_debug_port_assertions.sv
`timescale 1ns/100ps
// ==========================================================
// Port checker
module jtap_debug_port_assertions (
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic        tck,
  input wire logic        tdo,
  input wire logic        tdoOe,
  input wire logic [15:0] cpuInstr,
  input wire logic        cpuInstrStb,
  input wire logic        cpuResultValid,
  input wire logic        ocdDirty,
  input wire logic        pcValid,
  input wire logic        flowChange,
  input wire logic        dataAccess,
  input wire logic        breakReq
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  a_reset_quiet: assert property ($fell(rst) |-> !tdoOe && !ocdDirty && !breakReq
    && cpuInstr == 16'h0000) else $error("outputs active after reset");
  a_oe_on_fall: assert property ($changed(tdoOe) |-> !tck && !$past(tck))
    else $error("tdo enable moved outside low test clock");
  a_tdo_on_fall: assert property ($changed(tdo) |-> !tck && !$past(tck))
    else $error("tdo moved outside low test clock");
  a_tdo_parked: assert property (!tdoOe |-> tdo == 1'b0)
    else $error("tdo not parked while undriven");
  a_instr_with_stb: assert property ($changed(cpuInstr) |-> cpuInstrStb)
    else $error("cpu instruction changed without strobe");
  a_stb_single: assert property (cpuInstrStb |-> tck ##1 !cpuInstrStb)
    else $error("strobe not a single pulse after test clock rise");
  a_dirty_set: assert property (cpuResultValid |=> ocdDirty)
    else $error("dirty flag not set by result");
  a_dirty_clear: assert property ($fell(ocdDirty) |-> tck && !$past(cpuResultValid))
    else $error("dirty flag cleared outside update");
  a_break_cause: assert property (breakReq |-> $past(pcValid) || $past(flowChange)
    || $past(dataAccess)) else $error("break without cause");
endmodule : jtap_debug_port_assertions

bind jtap_debug_port jtap_debug_port_assertions chk_i (.*);

// File: testbench/jtap_host_model.sv
`timescale 1ns/100ps
// ==========================================================
// Scan host, 125 ns test clock
module jtap_host_model (
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo,
  input  wire logic tdoOe
);
  logic tdoLine;

  // Pulled-up pin when not driven
  assign tdoLine = tdoOe ? tdo : 1'b1;

  initial
  begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end

  task step(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    #62.5 tck = 1'b1;
    q = tdoLine;
    #62.5 tck = 1'b0;
  endtask : step

  task tlr;
    logic q;
    repeat (5) step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
  endtask : tlr

  task scan(input logic ir, input logic [71:0] din, input int n, output logic [71:0] dout);
    logic q;
    dout = '0;
    step(1'b1, 1'b0, q);
    if (ir)
      step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
    step(1'b0, 1'b0, q);
    for (int i = 0; i < n; i++)
    begin
      step(i == n - 1, din[i], q);
      dout[i] = q;
    end
    step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
  endtask : scan
endmodule : jtap_host_model

// File: testbench/jtag_tap_debug_port_bench.sv
`timescale 1ns/100ps
module jtag_tap_debug_port_bench;
  localparam logic [31:0] ID = 32'h1234_5671; // Arbitrary value
  logic        mclk, rst, tck, tms, tdi, tdo, tdoOe, cpuInstrStb, cpuResultValid, q;
  logic        ocdDirty, pcValid, flowChange, dataAccess, breakReq;
  logic [15:0] cpuInstr, pc, dataAddr;
  logic [7:0]  cpuResult;
  logic [71:0] dout;
  int          failCount, nChecks, cycles, stbCount;

  jtap_debug_port #(.IDCODE_VALUE(ID)) jtap_debug_port_i (
    .mclk           (mclk),
    .rst            (rst),
    .tck            (tck),
    .tms            (tms),
    .tdi            (tdi),
    .tdo            (tdo),
    .tdoOe          (tdoOe),
    .cpuInstr       (cpuInstr),
    .cpuInstrStb    (cpuInstrStb),
    .cpuResult      (cpuResult),
    .cpuResultValid (cpuResultValid),
    .ocdDirty       (ocdDirty),
    .pc             (pc),
    .pcValid        (pcValid),
    .flowChange     (flowChange),
    .dataAddr       (dataAddr),
    .dataAccess     (dataAccess),
    .breakReq       (breakReq)
  );
  jtap_host_model jtap_host_model_i (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdoOe(tdoOe));

  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  always @(posedge mclk)
  begin
    cycles++;
    if (cpuInstrStb === 1'b1)
      stbCount++;
    if (cycles == 20000)
    begin
      failCount++;
      complete_run();
    end
  end

  task chk(input string nm, input logic [71:0] seen, input logic [71:0] exp);
    nChecks++;
    if (seen !== exp)
    begin
      failCount++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // ==========================================================
  // Scenarios
  task test_idcode;
    jtap_host_model_i.tlr();
    jtap_host_model_i.scan(1'b0, 72'h0, 32, dout);
    chk("idcode", dout[31:0], ID);
  endtask : test_idcode

  task test_cpu_scan;
    jtap_host_model_i.scan(1'b1, 72'h8, 4, dout);
    chk("irCapture", dout[3:0], jtap_pkg::IR_CAPTURE_VAL);
    chk("instrHeld", cpuInstr, 16'h0000);
    jtap_host_model_i.scan(1'b0, 72'hA5C3, 16, dout);
    chk("cpuInstr", cpuInstr, 16'hA5C3);
    chk("stbCount", stbCount, 72'h1);
  endtask : test_cpu_scan

  task test_comm;
    @(posedge mclk);
    cpuResult <= 8'h96;
    cpuResultValid <= 1'b1;
    @(posedge mclk);
    cpuResult <= 8'h3C;
    @(posedge mclk);
    cpuResultValid <= 1'b0;
    jtap_host_model_i.scan(1'b1, 72'hA, 4, dout);
    jtap_host_model_i.scan(1'b0, 72'h0, 9, dout);
    chk("commRead", dout[8:0], 9'h13C);
    chk("dirtyClear", ocdDirty, 1'b0);
    jtap_host_model_i.scan(1'b0, 72'h0, 9, dout);
    chk("commEmpty", dout[8:0], 9'h03C);
  endtask : test_comm

  task ev(input logic [15:0] a, input logic [2:0] k, input logic exp);
    @(posedge mclk);
    pc <= a;
    dataAddr <= a;
    {pcValid, flowChange, dataAccess} <= k;
    @(posedge mclk);
    {pcValid, flowChange, dataAccess} <= 3'h0;
    @(negedge mclk);
    chk("breakReq", breakReq, exp);
  endtask : ev

  task test_break;
    jtap_host_model_i.scan(1'b1, 72'h9, 4, dout);
    jtap_host_model_i.scan(1'b0, 72'h01_2314, 72, dout);
    ev(16'h0123, 3'h4, 1'b1);
    ev(16'h0124, 3'h4, 1'b0);
    ev(16'h0000, 3'h2, 1'b1);
    jtap_host_model_i.scan(1'b0, 72'h00FF_0100_0000_0000_42, 72, dout);
    ev(16'h01A7, 3'h1, 1'b1);
    ev(16'h0200, 3'h1, 1'b0);
    ev(16'h0123, 3'h4, 1'b0);
  endtask : test_break

  task test_bypass_reset;
    jtap_host_model_i.scan(1'b1, 72'hF, 4, dout);
    jtap_host_model_i.scan(1'b0, 72'h1, 2, dout);
    chk("bypass", dout[1:0], 2'h2);
    jtap_host_model_i.step(1'b1, 1'b0, q);
    jtap_host_model_i.step(1'b0, 1'b0, q);
    jtap_host_model_i.step(1'b0, 1'b0, q);
    jtap_host_model_i.tlr();
    jtap_host_model_i.scan(1'b0, 72'h0, 32, dout);
    chk("idAfterReset", dout[31:0], ID);
  endtask : test_bypass_reset

  task complete_run;
    $display("Checks %0d, mismatches %0d", nChecks, failCount);
    if (failCount == 0 && nChecks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : complete_run

  initial
  begin
    rst = 1'b1;
    cpuResult = 8'h00;
    cpuResultValid = 1'b0;
    pc = 16'h0000;
    pcValid = 1'b0;
    flowChange = 1'b0;
    dataAddr = 16'h0000;
    dataAccess = 1'b0;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    test_idcode();
    test_cpu_scan();
    test_comm();
    test_break();
    test_bypass_reset();
    complete_run();
  end
endmodule : jtag_tap_debug_port_bench
